// ===== ucmc_pkg.sv
package ucmc_pkg;

	// apb register byte offsets
	localparam logic [7:0] UCMC_CTRL_OFF = 8'h00;
	localparam logic [7:0] UCMC_STAT_OFF = 8'h04;

	// control register fields
	localparam int UCMC_CTRL_SW_EN_POS = 0;
	localparam int UCMC_CTRL_DIS_EN_POS = 1;
	localparam logic [1:0] UCMC_CTRL_RST = 2'h1;

	// clock and timing
	localparam int UCMC_CLK_HZ = 10000000;
	localparam int UCMC_ILIM_DLY_NS = 2000;
	localparam int UCMC_CLK_NS = 1000000000 / UCMC_CLK_HZ;
	localparam int UCMC_ILIM_DLY_CYC = UCMC_ILIM_DLY_NS / UCMC_CLK_NS;
	localparam int UCMC_LOAD_ON_MS = 210;
	localparam int UCMC_LOAD_OFF_MS = 3000;
	localparam int UCMC_OC_DG_MS = 8;
	localparam int UCMC_OVP_DG_MS = 16;
	localparam int UCMC_DISCH_MS = 100;
	localparam int UCMC_CYC_PER_MS = UCMC_CLK_HZ / 1000;
	localparam int UCMC_LOAD_ON_CYC = UCMC_LOAD_ON_MS * UCMC_CYC_PER_MS;
	localparam int UCMC_LOAD_OFF_CYC = UCMC_LOAD_OFF_MS * UCMC_CYC_PER_MS;
	localparam int UCMC_OC_DG_CYC = UCMC_OC_DG_MS * UCMC_CYC_PER_MS;
	localparam int UCMC_OVP_DG_CYC = UCMC_OVP_DG_MS * UCMC_CYC_PER_MS;
	localparam int UCMC_DISCH_CYC = UCMC_DISCH_MS * UCMC_CYC_PER_MS;

	// mode-select codes
	localparam logic [2:0] UCMC_CODE_DCP_LO = 3'h0;
	localparam logic [2:0] UCMC_CODE_DCP = 3'h1;
	localparam logic [2:0] UCMC_CODE_SDP_LO = 3'h6;
	localparam logic [2:0] UCMC_CODE_CDP = 3'h7;

	typedef enum {
		UCMC_M_DCP_LO, UCMC_M_DCP, UCMC_M_SDP, UCMC_M_CLIENT,
		UCMC_M_SDP_LO, UCMC_M_CDP
	} ucmc_mode_t;

	typedef enum {UCMC_P_ON, UCMC_P_LIMIT, UCMC_P_THERM} ucmc_pwr_t;

	typedef enum {UCMC_A_IDLE, UCMC_A_DISCH, UCMC_A_SDP} ucmc_auto_t;

	// analog comparator inputs, grouped
	typedef struct packed {
		logic uv_ok;
		logic short_out;
		logic overload;
		logic load_above_hi;
		logic load_below_lo;
		logic temp_limiting;
		logic temp_normal;
		logic cooled;
		logic ovp;
		logic noncompliant;
		logic sdp_connected;
	} ucmc_sense_t;

	// decoded mode attributes
	typedef struct packed {
		logic hi_limit;
		logic load_en;
		logic fault_en;
		logic cs_en;
		logic client;
		logic oc_fault_mask;
	} ucmc_attr_t;

endpackage : ucmc_pkg

// ===== ucmc_top.sv
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ucmc_top
	import ucmc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic mode_select_bit1_i,
	input wire logic mode_select_bit2_i,
	input wire logic mode_select_bit3_i,
	input wire ucmc_sense_t sense_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic switch_on_o,
	output logic high_current_limit_o,
	output logic out_discharge_o,
	output logic data_switch_on_o,
	output logic data_bypass_o,
	output logic cs_en_o,
	output logic load_status_n_o,
	output logic load_status_n_oe_o,
	output logic fault_n_o,
	output logic fault_n_oe_o
);

	logic [2:0] code_m_ff, code_s_ff, code_d_ff;
	ucmc_sense_t sen_m_ff, sen_ff;
	ucmc_mode_t mode_ff, nxt_mode;
	ucmc_pwr_t pwr_ff;
	ucmc_auto_t auto_ff;
	ucmc_attr_t attr;
	logic [1:0] ctrl_ff;
	logic [31:0] ovl_cnt_ff, load_cnt_ff, oc_cnt_ff, ovp_cnt_ff, dis_cnt_ff;
	logic load_ff, oc_flt_ff, ovp_flt_ff, disch_ff;
	logic en, oc_now, fault_now;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	// two-flop synchroniser for pins and analog flags
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			code_m_ff <= 3'h0;
			code_s_ff <= 3'h0;
			code_d_ff <= 3'h0;
			sen_m_ff <= '0;
			sen_ff <= '0;
		end else begin
			code_m_ff <= {mode_select_bit1_i, mode_select_bit2_i,
				mode_select_bit3_i};
			code_s_ff <= code_m_ff;
			code_d_ff <= code_s_ff;
			sen_m_ff <= sense_i;
			sen_ff <= sen_m_ff;
		end
	end

	// decode; one stable cycle required so a skewed pin edge is ignored
	always_comb begin
		nxt_mode = mode_ff;
		if (code_s_ff == code_d_ff) begin
			case (code_d_ff[2:1])
				2'h0: nxt_mode = code_d_ff[0] ? UCMC_M_DCP : UCMC_M_DCP_LO;
				2'h1: nxt_mode = UCMC_M_SDP;
				2'h2: nxt_mode = UCMC_M_CLIENT;
				2'h3: nxt_mode = code_d_ff[0] ? UCMC_M_CDP : UCMC_M_SDP_LO;
				default: nxt_mode = mode_ff;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i)
			mode_ff <= UCMC_M_CLIENT;
		else
			mode_ff <= nxt_mode;
	end

	// mode attributes; auto fallback drops load status but keeps the high current limit
	always_comb begin
		attr = '0;
		case (mode_ff)
			UCMC_M_DCP_LO: attr = 6'b001101;
			UCMC_M_DCP: attr = 6'b111100;
			UCMC_M_SDP: attr = 6'b001100;
			UCMC_M_CLIENT: attr = 6'b000010;
			UCMC_M_SDP_LO: attr = 6'b001101;
			UCMC_M_CDP: attr = (auto_ff == UCMC_A_IDLE) ?
				6'b111100 : 6'b101100;
			default: attr = 6'b000010;
		endcase
	end

	// software switch enable gates the whole power path
	assign en = ctrl_ff[UCMC_CTRL_SW_EN_POS] && sen_ff.uv_ok &&
		!attr.client && !disch_ff;

	// power state: on, limiting, thermal off
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pwr_ff <= UCMC_P_THERM;
			ovl_cnt_ff <= 32'h0;
		end else begin
			case (pwr_ff)
				UCMC_P_ON: begin
					ovl_cnt_ff <= sen_ff.overload ? ovl_cnt_ff + 32'h1 : 32'h0;
					if (sen_ff.temp_normal)
						pwr_ff <= UCMC_P_THERM;
					else if (sen_ff.short_out && !switch_on_o)
						pwr_ff <= UCMC_P_LIMIT;
					else if (sen_ff.overload &&
						ovl_cnt_ff >= 32'(UCMC_ILIM_DLY_CYC - 1))
						pwr_ff <= UCMC_P_LIMIT;
				end
				UCMC_P_LIMIT: begin
					ovl_cnt_ff <= 32'h0;
					if (sen_ff.temp_limiting)
						pwr_ff <= UCMC_P_THERM;
					else if (!sen_ff.overload && !sen_ff.short_out)
						pwr_ff <= UCMC_P_ON;
				end
				UCMC_P_THERM: begin
					ovl_cnt_ff <= 32'h0;
					if (sen_ff.cooled)
						pwr_ff <= sen_ff.short_out ? UCMC_P_LIMIT
							: UCMC_P_ON;
				end
				default: pwr_ff <= UCMC_P_THERM;
			endcase
		end
	end

	// overcurrent deglitch, counting both edges
	assign oc_now = en && pwr_ff == UCMC_P_LIMIT;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			oc_cnt_ff <= 32'h0;
			oc_flt_ff <= 1'b0;
		end else if (oc_now == oc_flt_ff) begin
			oc_cnt_ff <= 32'h0;
		end else if (oc_cnt_ff >= 32'(UCMC_OC_DG_CYC - 1)) begin
			oc_cnt_ff <= 32'h0;
			oc_flt_ff <= oc_now;
		end else begin
			oc_cnt_ff <= oc_cnt_ff + 32'h1;
		end
	end

	// overvoltage: 16 ms to assert, immediate release
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ovp_cnt_ff <= 32'h0;
			ovp_flt_ff <= 1'b0;
		end else if (!sen_ff.ovp) begin
			ovp_cnt_ff <= 32'h0;
			ovp_flt_ff <= 1'b0;
		end else if (ovp_cnt_ff >= 32'(UCMC_OVP_DG_CYC - 1)) begin
			ovp_flt_ff <= 1'b1;
		end else begin
			ovp_cnt_ff <= ovp_cnt_ff + 32'h1;
		end
	end

	// load status filter; counters long, intentional low power limitation
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			load_cnt_ff <= 32'h0;
			load_ff <= 1'b0;
		end else if (!attr.load_en || !en) begin
			load_cnt_ff <= 32'h0;
			load_ff <= 1'b0;
		end else if (load_ff ? !sen_ff.load_below_lo
			: !sen_ff.load_above_hi) begin
			load_cnt_ff <= 32'h0;
		end else if (load_cnt_ff >= 32'(load_ff ? UCMC_LOAD_OFF_CYC - 1
			: UCMC_LOAD_ON_CYC - 1)) begin
			load_cnt_ff <= 32'h0;
			load_ff <= !load_ff;
		end else begin
			load_cnt_ff <= load_cnt_ff + 32'h1;
		end
	end

	// charging-to-standard fallback, only code 111 starts a discharge
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			auto_ff <= UCMC_A_IDLE;
			disch_ff <= 1'b0;
			dis_cnt_ff <= 32'h0;
		end else if (mode_ff != UCMC_M_CDP) begin
			auto_ff <= UCMC_A_IDLE;
			disch_ff <= 1'b0;
			dis_cnt_ff <= 32'h0;
		end else begin
			case (auto_ff)
				UCMC_A_IDLE: if (sen_ff.noncompliant &&
					ctrl_ff[UCMC_CTRL_DIS_EN_POS]) begin
					auto_ff <= UCMC_A_DISCH;
					disch_ff <= 1'b1;
				end
				UCMC_A_DISCH: begin
					dis_cnt_ff <= dis_cnt_ff + 32'h1;
					if (dis_cnt_ff >= 32'(UCMC_DISCH_CYC - 1)) begin
						auto_ff <= UCMC_A_SDP;
						disch_ff <= 1'b0;
						dis_cnt_ff <= 32'h0;
					end
				end
				UCMC_A_SDP: if (sen_ff.sdp_connected)
					auto_ff <= UCMC_A_IDLE;
				default: auto_ff <= UCMC_A_IDLE;
			endcase
		end
	end

	// fault sources; overtemperature masked by mode only in client mode
	assign fault_now = attr.fault_en && ((pwr_ff == UCMC_P_THERM &&
		sen_ff.uv_ok) || (oc_flt_ff && !attr.oc_fault_mask) ||
		ovp_flt_ff);

	// registered pin drivers
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			switch_on_o <= 1'b0;
			high_current_limit_o <= 1'b0;
			out_discharge_o <= 1'b0;
			data_switch_on_o <= 1'b0;
			data_bypass_o <= 1'b0;
			cs_en_o <= 1'b0;
			load_status_n_oe_o <= 1'b0;
			fault_n_oe_o <= 1'b0;
		end else begin
			switch_on_o <= en && pwr_ff != UCMC_P_THERM;
			high_current_limit_o <= attr.hi_limit;
			out_discharge_o <= disch_ff;
			data_switch_on_o <= !sen_ff.ovp && !attr.client &&
				pwr_ff != UCMC_P_THERM;
			data_bypass_o <= attr.client && !sen_ff.ovp;
			cs_en_o <= attr.cs_en && en;
			load_status_n_oe_o <= load_ff && attr.load_en && en;
			fault_n_oe_o <= fault_now;
		end
	end

	// open-drain outputs only ever pull low
	assign load_status_n_o = 1'b0;
	assign fault_n_o = 1'b0;

	// apb slave, zero wait state; unmapped reads zero with error
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i)
			ctrl_ff <= UCMC_CTRL_RST;
		else if (psel_i && penable_i && pwrite_i &&
			paddr_i == UCMC_CTRL_OFF)
			ctrl_ff <= pwdata_i[1:0];
	end

	// answers latched in the setup cycle so the access phase has no wait
	always_ff @(posedge ref_clk_i) begin
		pready_o <= 1'b1;
		if (!rst_n_i) begin
			prdata_o <= 32'h0;
			pslverr_o <= 1'b0;
		end else begin
			pslverr_o <= psel_i && !penable_i &&
				paddr_i != UCMC_CTRL_OFF && paddr_i != UCMC_STAT_OFF;
			if (psel_i && !penable_i)
				prdata_o <= (paddr_i == UCMC_CTRL_OFF) ? {30'h0, ctrl_ff} :
					(paddr_i == UCMC_STAT_OFF) ? {20'h0, code_d_ff,
					3'(mode_ff), 2'(pwr_ff), 2'(auto_ff), fault_now,
					load_ff} : 32'h0;
		end
	end

	a_oc_mask: assert property (
		attr.oc_fault_mask && pwr_ff != UCMC_P_THERM && !ovp_flt_ff
		|=> !fault_n_oe_o) else $error("oc fault not masked");
	a_therm_fault: assert property (
		pwr_ff == UCMC_P_THERM && attr.fault_en && sen_ff.uv_ok
		|=> fault_n_oe_o && !switch_on_o) else $error("no thermal fault");
	a_client_off: assert property (
		mode_ff == UCMC_M_CLIENT |=> !switch_on_o && !fault_n_oe_o &&
		!cs_en_o && !load_status_n_oe_o) else $error("client active");
	a_no_disch: assert property (
		mode_ff != UCMC_M_CDP
		|=> !disch_ff) else $error("unexpected discharge");
	a_lim_trip: assert property (
		pwr_ff == UCMC_P_LIMIT && sen_ff.temp_limiting
		|=> pwr_ff == UCMC_P_THERM) else $error("limit thermal trip missed");
	a_norm_hold: assert property (
		pwr_ff == UCMC_P_ON && !sen_ff.temp_normal
		|=> pwr_ff != UCMC_P_THERM) else $error("early thermal");
	a_ovp_release: assert property (
		!sen_ff.ovp
		|=> !ovp_flt_ff) else $error("ovp held");
	a_ovp_open: assert property (
		sen_ff.ovp
		|=> !data_switch_on_o && !data_bypass_o) else $error("data switch on");
	a_uv_off: assert property (
		!sen_ff.uv_ok
		|=> !switch_on_o) else $error("on in uv");
	a_mode_dcp: assert property (
		code_s_ff == 3'h1 && code_d_ff == 3'h1
		|=> mode_ff == UCMC_M_DCP) else $error("decode wrong");
	c_limit: cover property (@(posedge ref_clk_i) pwr_ff == UCMC_P_LIMIT);
	c_fallback: cover property (@(posedge ref_clk_i)
		auto_ff == UCMC_A_SDP);
	c_ovp: cover property (@(posedge ref_clk_i) ovp_flt_ff);

endmodule : ucmc_top
`default_nettype wire

// ===== ucmc_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module ucmc_port_model
	import ucmc_pkg::*;
(
	input wire logic switch_on_i,
	input wire ucmc_sense_t knob_i,
	output ucmc_sense_t sense_o
);
	// comparator levels follow the load; a phone only misreads a live port
	always_comb begin
		sense_o = knob_i;
		sense_o.noncompliant = knob_i.noncompliant & switch_on_i;
	end
endmodule : ucmc_port_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import ucmc_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] code = 3'h7;
	ucmc_sense_t knob = '0;
	ucmc_sense_t sense;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, sw, hi, disch, byp, cs, flt;
	logic dsw, lst, lsn, fln;
	logic watch = 1'b0;
	logic seen = 1'b0;
	logic [31:0] rd, v;
	logic err;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [2:0] seq [7] = '{3'h0, 3'h1, 3'h0, 3'h6, 3'h7, 3'h6, 3'h7};
	logic wseq [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

	ucmc_top uut (.ref_clk_i(clk), .rst_n_i(rst_n),
		.mode_select_bit1_i(code[2]), .mode_select_bit2_i(code[1]),
		.mode_select_bit3_i(code[0]), .sense_i(sense), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .switch_on_o(sw), .high_current_limit_o(hi),
		.out_discharge_o(disch), .data_switch_on_o(dsw), .data_bypass_o(byp),
		.cs_en_o(cs), .load_status_n_o(lsn), .load_status_n_oe_o(lst),
		.fault_n_o(fln), .fault_n_oe_o(flt));
	ucmc_port_model partner (.switch_on_i(sw), .knob_i(knob),
		.sense_o(sense));

	// free-running clock, 100 ns period
	always #50 clk = ~clk;

	// sticky discharge flag over mode changes that must not discharge
	always @(posedge clk) begin
		if (watch && disch === 1'b1) begin
			seen <= 1'b1;
		end
	end

	// hang guard: far above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			$display("BAD timeout exp done got hung");
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt

	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [2:0] mode_of(input logic [2:0] c);
		case (c)
			UCMC_CODE_DCP_LO: return 3'(UCMC_M_DCP_LO);
			UCMC_CODE_DCP: return 3'(UCMC_M_DCP);
			UCMC_CODE_SDP_LO: return 3'(UCMC_M_SDP_LO);
			UCMC_CODE_CDP: return 3'(UCMC_M_CDP);
			3'h2, 3'h3: return 3'(UCMC_M_SDP);
			default: return 3'(UCMC_M_CLIENT);
		endcase
	endfunction : mode_of

	// host drives a new code, then mode and pins are compared
	task automatic mode(input logic [2:0] c, input logic w);
		logic cl;
		cl = (c[2:1] == 2'b10);
		@(posedge clk);
		code <= c;
		watch <= w;
		wt(10);
		apb(1'b0, UCMC_STAT_OFF, 32'h0);
		chk("mode", 32'(mode_of(c)), 32'(rd[8:6]));
		chk("code", 32'(c), 32'(rd[11:9]));
		chk("cs_en", 32'(!cl), 32'(cs));
		chk("bypass", 32'(cl), 32'(byp));
		chk("data_sw", 32'(!cl), 32'(dsw));
		chk("load_st", 32'h0, 32'(lst));
		chk("switch", 32'(!cl), 32'(sw));
		if (!cl) begin
			chk("limit", 32'(c == 3'h1 || c == 3'h7), 32'(hi));
		end
	endtask : mode

	task automatic power(input string nm, input ucmc_pwr_t p);
		apb(1'b0, UCMC_STAT_OFF, 32'h0);
		chk(nm, 32'(p), 32'(rd[5:4]));
	endtask : power

	// main sequence
	initial begin
		knob.uv_ok = 1'b1;
		knob.cooled = 1'b1;
		void'($urandom(32'h5fc9));
		wt(6);
		rst_n <= 1'b1;
		wt(12);
		apb(1'b0, UCMC_CTRL_OFF, 32'h0);
		chk("ctrl_rst", 32'(UCMC_CTRL_RST), rd);
		apb(1'b1, 8'h08, 32'hffffffff);
		apb(1'b0, 8'h08, 32'h0);
		chk("unmapped_err", 32'h1, 32'(err));
		chk("unmapped_rd", 32'h0, rd);
		v = ($urandom() & 32'h2) | 32'h1;
		apb(1'b1, UCMC_CTRL_OFF, v);
		apb(1'b0, UCMC_CTRL_OFF, 32'h0);
		chk("ctrl_rw", v, rd);
		apb(1'b1, UCMC_CTRL_OFF, 32'h3);
		$display("test registers done");
		// toggles inside each mode pair must not discharge the port
		for (int i = 0; i < 7; i++) begin
			mode(seq[i], wseq[i]);
		end
		watch <= 1'b0;
		chk("no_discharge", 32'h0, 32'(seen));
		for (int i = 0; i < 12; i++) begin
			mode(3'($urandom() % 8), 1'b0);
		end
		mode(3'h7, 1'b0);
		$display("test modes done");
		knob.temp_limiting <= 1'b1;
		wt(8);
		chk("hot_not_limiting", 32'h1, 32'(sw));
		knob.temp_normal <= 1'b1;
		knob.cooled <= 1'b0;
		wt(8);
		chk("hot_trip", 32'h0, 32'(sw));
		chk("hot_fault", 32'h1, 32'(flt));
		knob <= '{uv_ok: 1'b1, cooled: 1'b1, default: 1'b0};
		wt(8);
		chk("restart", 32'h1, 32'(sw));
		chk("fault_clear", 32'h0, 32'(flt));
		knob.overload <= 1'b1;
		wt(5);
		power("early", UCMC_P_ON);
		wt(25);
		power("limiting", UCMC_P_LIMIT);
		chk("limit_on", 32'h1, 32'(sw));
		chk("oc_deglitch", 32'h0, 32'(flt));
		knob.temp_limiting <= 1'b1;
		knob.cooled <= 1'b0;
		wt(8);
		chk("limit_trip", 32'h0, 32'(sw));
		chk("limit_fault", 32'h1, 32'(flt));
		knob <= '{uv_ok: 1'b1, cooled: 1'b1, default: 1'b0};
		wt(10);
		chk("cycle_on", 32'h1, 32'(sw));
		$display("test thermal done");
		knob.uv_ok <= 1'b0;
		wt(8);
		chk("uv_off", 32'h0, 32'(sw));
		knob.uv_ok <= 1'b1;
		wt(10);
		chk("uv_on", 32'h1, 32'(sw));
		apb(1'b1, UCMC_CTRL_OFF, 32'h0);
		wt(8);
		chk("sw_disabled", 32'h0, 32'(sw));
		knob.short_out <= 1'b1;
		apb(1'b1, UCMC_CTRL_OFF, 32'h1);
		wt(4);
		power("short_at_enable", UCMC_P_LIMIT);
		knob.short_out <= 1'b0;
		wt(10);
		$display("test limit done");
		knob.ovp <= 1'b1;
		knob.load_above_hi <= 1'b1;
		wt(6);
		chk("ovp_open", 32'h0, 32'(dsw));
		chk("ovp_no_fault", 32'h0, 32'(flt));
		chk("load_wait", 32'h0, 32'(lst));
		knob.ovp <= 1'b0;
		knob.load_above_hi <= 1'b0;
		wt(6);
		chk("ovp_close", 32'h1, 32'(dsw));
		chk("od_pins", 32'h0, 32'({lsn, fln}));
		$display("test ovp done");
		apb(1'b1, UCMC_CTRL_OFF, 32'h3);
		knob.noncompliant <= 1'b1;
		wt(8);
		chk("fallback_disch", 32'h1, 32'(disch));
		chk("fallback_off", 32'h0, 32'(sw));
		// second reset in mid-discharge
		rst_n <= 1'b0;
		knob.noncompliant <= 1'b0;
		wt(2);
		chk("rst_disch", 32'h0, 32'(disch));
		chk("rst_ready", 32'h1, 32'(pready));
		rst_n <= 1'b1;
		wt(12);
		apb(1'b0, UCMC_CTRL_OFF, 32'h0);
		chk("ctrl_rst2", 32'(UCMC_CTRL_RST), rd);
		$display("test fallback done");
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
